// ---- ncals_pkg.sv ----
// Constants, opcodes and types for the nibble execution block
//
// Contract
// (RQ1) Rotate-left moves carry into bit 0, bit 3 into carry; both flags updated.
// (RQ2) Accumulator/extension swap, one byte, one cycle, flags untouched.
// (RQ3) Memory and accumulator bump/drop by one, updating zero and carry flags.
// (RQ4) Set bit of addressed nibble chosen by opcode bits 1:0; flags untouched.
// (RQ5) Clear bit of addressed nibble chosen by opcode bits 1:0; zero flag updated.
// (RQ6) Accumulator gets accumulator plus memory; zero and carry updated.
// (RQ7) Accumulator gets accumulator plus memory plus carry; zero and carry updated.
// (RQ8) Add six to accumulator; only zero flag updated.
// (RQ9) Add ten to accumulator; only zero flag updated.
// (RQ10) Accumulator becomes accumulator xor memory; zero flag updated.
// (RQ11) Accumulator becomes accumulator and memory; zero flag updated.
// (RQ12) Accumulator becomes accumulator or memory; zero flag updated.
// (RQ13) Memory compare: greater 0/0, equal 1/1, smaller 1/0 for carry/zero.
// (RQ14) Immediate compare, two bytes, two cycles, same flag outcome as memory compare.
// (RQ15) Pointer low xor immediate sets only zero flag; nothing else written.
// (RQ16) Load immediate copies opcode low nibble into accumulator; zero flag updated.
// (RQ17) Swap accumulator with memory, then pointer high xor 0,imm3; two cycles.
// (RQ18) Plain memory swap takes two cycles; zero flag follows pointer high.
// (RQ19) Swap then pointer low bump or drop; zero follows pointer; two cycles.
// (RQ20) Table read from {pc high, ext, acc} into acc and ext over two cycles.
// (RQ21) Invert every accumulator bit; zero flag updated.
// (RQ22) Zero flag set when the 4-bit result is zero, unless compare decides.
// (RQ23) Clear acc, carry clear/set, store and load behave as plain moves.
// (RQ24) Every other single-byte opcode completes in one instruction cycle.

package ncals_pkg;

    // -----------------------------------------------------------------
    // Opcodes
    // -----------------------------------------------------------------
    localparam logic [7:0] OP_ROTL       = 8'h01;
    localparam logic [7:0] OP_STORE      = 8'h02;
    localparam logic [7:0] OP_TO_EXT     = 8'h03;
    localparam logic [7:0] OP_SWAP_EXT   = 8'h0d;
    localparam logic [7:0] OP_ACC_BUMP   = 8'h0e;
    localparam logic [7:0] OP_ACC_DROP   = 8'h0f;
    localparam logic [7:0] OP_SET_BIT    = 8'h08;
    localparam logic [7:0] OP_CARRY_SUM  = 8'h20;
    localparam logic [7:0] OP_LOAD       = 8'h21;
    localparam logic [7:0] OP_CLR_BIT    = 8'h28;
    localparam logic [7:0] OP_IMM_CMP    = 8'h2c;
    localparam logic [7:0] OP_PLOW_CMP   = 8'h2d;
    localparam logic [7:0] OP_MEM_BUMP   = 8'h2e;
    localparam logic [7:0] OP_MEM_DROP   = 8'h2f;
    localparam logic [7:0] OP_BIN_SUM    = 8'h60;
    localparam logic [7:0] OP_ROM_READ   = 8'h63;
    localparam logic [7:0] OP_SWAP_XOR   = 8'ha0;
    localparam logic [3:0] OP_LOAD_IMM_H = 4'hc;
    localparam logic [7:0] OP_CARRY_CLR  = 8'he1;
    localparam logic [7:0] OP_OR_MEM     = 8'he5;
    localparam logic [7:0] OP_BCD_ADD    = 8'he6;
    localparam logic [7:0] OP_AND_MEM    = 8'he7;
    localparam logic [7:0] OP_BCD_SUB    = 8'hea;
    localparam logic [7:0] OP_INVERT     = 8'heb;
    localparam logic [7:0] OP_CARRY_SET  = 8'hf1;
    localparam logic [7:0] OP_XOR_MEM    = 8'hf5;
    localparam logic [7:0] OP_MEM_CMP    = 8'hfb;
    localparam logic [7:0] OP_SWAP_BUMP  = 8'hfe;
    localparam logic [7:0] OP_SWAP_DROP  = 8'hff;

    // Masks for opcode families with operand bits
    localparam logic [7:0] MASK_BIT_OP   = 8'hfc;
    localparam logic [7:0] MASK_SWAP_XOR = 8'hf8;

    // -----------------------------------------------------------------
    // Arithmetic constants and reset values
    // -----------------------------------------------------------------
    localparam logic [3:0] NIB_ONE       = 4'h1;
    localparam logic [3:0] NIB_ALL       = 4'hf;
    localparam logic [3:0] BCD_ADJ_ADD   = 4'h6;
    localparam logic [3:0] BCD_ADJ_SUB   = 4'ha;
    localparam logic [3:0] RST_NIB       = 4'h0;
    localparam logic       RST_FLAG      = 1'b0;
    localparam int         RAM_WORDS     = 256;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ALU_ADD, ALU_XOR, ALU_AND, ALU_OR, ALU_INV, ALU_ROL
    } ncals_alu_op_t;

    typedef enum logic {ST_EXEC, ST_SECOND} ncals_state_t;

endpackage

// ---- ncals_ifs.sv ----
// Internal carriers between the core, the nibble ALU and the data memory
`timescale 1ns/10ps

interface ncals_alu_if;
    ncals_pkg::ncals_alu_op_t op;
    logic [3:0]               a;
    logic [3:0]               b;
    logic                     cin;
    logic [3:0]               res;
    logic                     cout;
    modport core (output op, a, b, cin, input res, cout);
    modport alu  (input op, a, b, cin, output res, cout);
endinterface

interface ncals_ram_if;
    logic [7:0] addr;
    logic       wr;
    logic [3:0] wdata;
    logic [3:0] rdata;
    modport core (output addr, wr, wdata, input rdata);
    modport ram  (input addr, wr, wdata, output rdata);
endinterface

// ---- ncals_alu.sv ----
// Combinational 4-bit ALU
`timescale 1ns/10ps

module ncals_alu (
    // Operands and result
    ncals_alu_if.alu a_if
);

    wire [4:0] sum;

    // Five-bit sum keeps the carry out
    assign sum = {1'b0, a_if.a} + {1'b0, a_if.b} + {4'h0, a_if.cin};

    // Result select
    always_comb begin
        a_if.res  = sum[3:0];
        a_if.cout = sum[4];
        case (a_if.op)
            ncals_pkg::ALU_ADD: begin
                a_if.res  = sum[3:0];
                a_if.cout = sum[4];
            end
            ncals_pkg::ALU_XOR: a_if.res = a_if.a ^ a_if.b;
            ncals_pkg::ALU_AND: a_if.res = a_if.a & a_if.b;
            ncals_pkg::ALU_OR:  a_if.res = a_if.a | a_if.b;
            ncals_pkg::ALU_INV: a_if.res = ~a_if.a;
            ncals_pkg::ALU_ROL: begin
                a_if.res  = {a_if.a[2:0], a_if.cin}; // [RQ1]
                a_if.cout = a_if.a[3];               // [RQ1]
            end
            default: a_if.res = sum[3:0];
        endcase
    end

endmodule

// ---- ncals_ram.sv ----
// Data memory of 256 nibbles, read combinationally, written on the clock
`timescale 1ns/10ps

module ncals_ram (
    // Clock and enable
    input  wire logic     clk,
    input  wire logic     ce,
    // Access port
    ncals_ram_if.ram      r_if
);

    logic [3:0] mem_r [ncals_pkg::RAM_WORDS];

    // Read of the addressed nibble
    assign r_if.rdata = mem_r[r_if.addr];

    // Write, frozen while the enable is low
    always_ff @(posedge clk) begin
        if (ce && r_if.wr) begin
            mem_r[r_if.addr] <= r_if.wdata;
        end
    end

endmodule

// ---- ncals_core.sv ----
// Execution core for accumulator, memory, arithmetic, compare and load/store opcodes
`timescale 1ns/10ps

module ncals_core (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Opcode hand-in
    input  wire logic        op_valid,
    input  wire logic [7:0]  op_code,
    input  wire logic [7:0]  op_imm,
    output logic             op_ready,
    output logic             op_done,
    // Pointer load from the pointer group
    input  wire logic        ptr_wr,
    input  wire logic [7:0]  ptr_wdata,
    // Program ROM table port
    input  wire logic [3:0]  pc_high,
    output logic             rom_rd,
    output logic [11:0]      rom_addr,
    input  wire logic [7:0]  rom_data,
    // Architectural state
    output logic [3:0]       acc,
    output logic [3:0]       ext,
    output logic [7:0]       mem_ptr,
    output logic             carry_flag,
    output logic             zero_flag
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic is_zero(input logic [3:0] v);
        is_zero = (v == 4'h0);
    endfunction

    function automatic logic [3:0] bit_mask(input logic [1:0] sel);
        bit_mask = 4'h1 << sel;
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    ncals_pkg::ncals_state_t state_r, state_nxt;
    logic [3:0]  acc_r, acc_nxt;
    logic [3:0]  ext_r, ext_nxt;
    logic [3:0]  pth_r, pth_nxt;
    logic [3:0]  ptl_r, ptl_nxt;
    logic        cy_r, cy_nxt;
    logic        zr_r, zr_nxt;
    logic [7:0]  op_r, op_nxt;
    logic [3:0]  imm_r, imm_nxt;
    logic        done_r, done_nxt;
    logic        rom_rd_r, rom_rd_nxt;
    logic [11:0] rom_addr_r, rom_addr_nxt;

    ncals_alu_if alu_bus ();
    ncals_ram_if ram_bus ();

    ncals_alu u_alu (
        .a_if (alu_bus)
    );

    ncals_ram u_ram (
        .clk  (clk),
        .ce   (ce),
        .r_if (ram_bus)
    );

    // -----------------------------------------------------------------
    // Phase and decode
    // -----------------------------------------------------------------
    wire       in_second;
    wire       exec_go;
    wire       fin_go;
    wire [7:0] cur_op;
    wire [3:0] mem_val;

    // One decoder serves both phases
    assign in_second = (state_r == ncals_pkg::ST_SECOND);
    assign exec_go   = ce && op_valid && !in_second;
    assign fin_go    = ce && in_second;
    assign cur_op    = in_second ? op_r : op_code;
    assign mem_val   = ram_bus.rdata;
    assign ram_bus.addr = {pth_r, ptl_r};

    wire d_rotl      = (cur_op == ncals_pkg::OP_ROTL);
    wire d_store     = (cur_op == ncals_pkg::OP_STORE);
    wire d_to_ext    = (cur_op == ncals_pkg::OP_TO_EXT);
    wire d_swap_ext  = (cur_op == ncals_pkg::OP_SWAP_EXT);
    wire d_acc_bump  = (cur_op == ncals_pkg::OP_ACC_BUMP);
    wire d_acc_drop  = (cur_op == ncals_pkg::OP_ACC_DROP);
    wire d_set_bit   = ((cur_op & ncals_pkg::MASK_BIT_OP) == ncals_pkg::OP_SET_BIT);
    wire d_clr_bit   = ((cur_op & ncals_pkg::MASK_BIT_OP) == ncals_pkg::OP_CLR_BIT);
    wire d_carry_sum = (cur_op == ncals_pkg::OP_CARRY_SUM);
    wire d_load      = (cur_op == ncals_pkg::OP_LOAD);
    wire d_imm_cmp   = (cur_op == ncals_pkg::OP_IMM_CMP);
    wire d_plow_cmp  = (cur_op == ncals_pkg::OP_PLOW_CMP);
    wire d_mem_bump  = (cur_op == ncals_pkg::OP_MEM_BUMP);
    wire d_mem_drop  = (cur_op == ncals_pkg::OP_MEM_DROP);
    wire d_bin_sum   = (cur_op == ncals_pkg::OP_BIN_SUM);
    wire d_rom_read  = (cur_op == ncals_pkg::OP_ROM_READ);
    wire d_swap_xor  = ((cur_op & ncals_pkg::MASK_SWAP_XOR) == ncals_pkg::OP_SWAP_XOR);
    wire d_load_imm  = (cur_op[7:4] == ncals_pkg::OP_LOAD_IMM_H);
    wire d_carry_clr = (cur_op == ncals_pkg::OP_CARRY_CLR);
    wire d_or_mem    = (cur_op == ncals_pkg::OP_OR_MEM);
    wire d_bcd_add   = (cur_op == ncals_pkg::OP_BCD_ADD);
    wire d_and_mem   = (cur_op == ncals_pkg::OP_AND_MEM);
    wire d_bcd_sub   = (cur_op == ncals_pkg::OP_BCD_SUB);
    wire d_invert    = (cur_op == ncals_pkg::OP_INVERT);
    wire d_carry_set = (cur_op == ncals_pkg::OP_CARRY_SET);
    wire d_xor_mem   = (cur_op == ncals_pkg::OP_XOR_MEM);
    wire d_mem_cmp   = (cur_op == ncals_pkg::OP_MEM_CMP);
    wire d_swap_bump = (cur_op == ncals_pkg::OP_SWAP_BUMP);
    wire d_swap_drop = (cur_op == ncals_pkg::OP_SWAP_DROP);

    // Groups by effect
    wire g_swap_mem  = d_swap_xor || d_swap_bump || d_swap_drop;
    wire g_two_cyc   = g_swap_mem || d_imm_cmp || d_plow_cmp || d_rom_read;
    wire g_acc_cz    = d_rotl || d_acc_bump || d_acc_drop || d_bin_sum || d_carry_sum;
    wire g_acc_z     = d_bcd_add || d_bcd_sub || d_xor_mem || d_and_mem || d_or_mem
                       || d_invert;
    wire g_mem_cz    = d_mem_bump || d_mem_drop;

    // -----------------------------------------------------------------
    // ALU operand selection
    // -----------------------------------------------------------------
    wire use_mem_a   = d_mem_bump || d_mem_drop;
    wire use_ptl_a   = d_swap_bump || d_swap_drop;
    wire add_one     = d_acc_bump || d_mem_bump || d_swap_bump;
    wire add_all     = d_acc_drop || d_mem_drop || d_swap_drop;

    assign alu_bus.op  = d_rotl     ? ncals_pkg::ALU_ROL :
                         (d_xor_mem || d_swap_xor) ? ncals_pkg::ALU_XOR :
                         d_and_mem  ? ncals_pkg::ALU_AND :
                         d_or_mem   ? ncals_pkg::ALU_OR  :
                         d_invert   ? ncals_pkg::ALU_INV : ncals_pkg::ALU_ADD;
    assign alu_bus.a   = use_mem_a ? mem_val : use_ptl_a ? ptl_r :
                         d_swap_xor ? pth_r : acc_r;
    assign alu_bus.b   = add_one   ? ncals_pkg::NIB_ONE :
                         add_all   ? ncals_pkg::NIB_ALL :
                         d_bcd_add ? ncals_pkg::BCD_ADJ_ADD :
                         d_bcd_sub ? ncals_pkg::BCD_ADJ_SUB :
                         d_swap_xor ? {1'b0, op_r[2:0]} : mem_val;
    assign alu_bus.cin = (d_rotl || d_carry_sum) ? cy_r : 1'b0;

    wire [3:0] res  = alu_bus.res;
    wire [3:0] mask = bit_mask(cur_op[1:0]);
    wire [3:0] cimm = imm_r;

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        acc_nxt       = acc_r;
        ext_nxt       = ext_r;
        pth_nxt       = pth_r;
        ptl_nxt       = ptl_r;
        cy_nxt        = cy_r;
        zr_nxt        = zr_r;
        op_nxt        = op_r;
        imm_nxt       = imm_r;
        done_nxt      = 1'b0;
        rom_rd_nxt    = rom_rd_r;
        rom_addr_nxt  = rom_addr_r;
        ram_bus.wr    = 1'b0;
        ram_bus.wdata = acc_r;
        if (exec_go) begin
            if (g_acc_cz) begin
                acc_nxt = res;                               // [RQ1] [RQ3] [RQ6] [RQ7]
                cy_nxt  = alu_bus.cout;
                zr_nxt  = is_zero(res);                      // [RQ22]
            end
            if (g_acc_z) begin
                acc_nxt = res;                   // [RQ8] [RQ9] [RQ10] [RQ11] [RQ12] [RQ21]
                zr_nxt  = is_zero(res);
            end
            if (g_mem_cz) begin
                ram_bus.wr    = 1'b1;                        // [RQ3]
                ram_bus.wdata = res;
                cy_nxt        = alu_bus.cout;
                zr_nxt        = is_zero(res);
            end
            if (d_load_imm) begin
                acc_nxt = cur_op[3:0];                       // [RQ16] [RQ23]
                zr_nxt  = is_zero(cur_op[3:0]);
            end
            if (d_swap_ext) begin
                acc_nxt = ext_r;                             // [RQ2]
                ext_nxt = acc_r;
            end
            if (d_to_ext) begin
                ext_nxt = acc_r;
            end
            if (d_set_bit) begin
                ram_bus.wr    = 1'b1;                        // [RQ4]
                ram_bus.wdata = mem_val | mask;
            end
            if (d_clr_bit) begin
                ram_bus.wr    = 1'b1;                        // [RQ5]
                ram_bus.wdata = mem_val & ~mask;
                zr_nxt        = is_zero(mem_val & ~mask);
            end
            if (d_store) begin
                ram_bus.wr = 1'b1;                           // [RQ23]
            end
            if (d_load) begin
                acc_nxt = mem_val;                           // [RQ23]
                zr_nxt  = is_zero(mem_val);
            end
            if (d_carry_clr) begin
                cy_nxt = 1'b0;                               // [RQ23]
            end
            if (d_carry_set) begin
                cy_nxt = 1'b1;                               // [RQ23]
            end
            if (d_mem_cmp) begin
                cy_nxt = (mem_val <= acc_r);                 // [RQ13]
                zr_nxt = (mem_val == acc_r);
            end
            if (g_swap_mem) begin
                acc_nxt    = mem_val;                        // [RQ17] [RQ18] [RQ19]
                ram_bus.wr = 1'b1;
            end
            if (d_rom_read) begin
                rom_addr_nxt = {pc_high, ext_r, acc_r};      // [RQ20]
                rom_rd_nxt   = 1'b1;
            end
            if (g_two_cyc) begin
                state_nxt = ncals_pkg::ST_SECOND;            // [RQ14] [RQ17] [RQ20]
                op_nxt    = op_code;
                imm_nxt   = op_imm[3:0];
            end else begin
                done_nxt  = 1'b1;                            // [RQ24]
            end
        end else if (fin_go) begin
            if (d_swap_xor) begin
                pth_nxt = res;                               // [RQ17] [RQ18]
                zr_nxt  = is_zero(res);
            end
            if (d_swap_bump || d_swap_drop) begin
                ptl_nxt = res;                               // [RQ19]
                zr_nxt  = is_zero(res);
            end
            if (d_imm_cmp) begin
                cy_nxt = (cimm <= acc_r);                    // [RQ14]
                zr_nxt = (cimm == acc_r);
            end
            if (d_plow_cmp) begin
                zr_nxt = is_zero(ptl_r ^ cimm);              // [RQ15]
            end
            if (d_rom_read) begin
                acc_nxt    = rom_data[7:4];                  // [RQ20]
                ext_nxt    = rom_data[3:0];
                rom_rd_nxt = 1'b0;
            end
            state_nxt = ncals_pkg::ST_EXEC;
            done_nxt  = 1'b1;
        end else if (ce && ptr_wr && !in_second) begin
            pth_nxt = ptr_wdata[7:4];
            ptl_nxt = ptr_wdata[3:0];
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r    <= ncals_pkg::ST_EXEC;
            acc_r      <= ncals_pkg::RST_NIB;
            ext_r      <= ncals_pkg::RST_NIB;
            pth_r      <= ncals_pkg::RST_NIB;
            ptl_r      <= ncals_pkg::RST_NIB;
            cy_r       <= ncals_pkg::RST_FLAG;
            zr_r       <= ncals_pkg::RST_FLAG;
            op_r       <= {2{ncals_pkg::RST_NIB}};
            imm_r      <= ncals_pkg::RST_NIB;
            done_r     <= ncals_pkg::RST_FLAG;
            rom_rd_r   <= ncals_pkg::RST_FLAG;
            rom_addr_r <= {3{ncals_pkg::RST_NIB}};
        end else if (ce) begin
            state_r    <= state_nxt;
            acc_r      <= acc_nxt;
            ext_r      <= ext_nxt;
            pth_r      <= pth_nxt;
            ptl_r      <= ptl_nxt;
            cy_r       <= cy_nxt;
            zr_r       <= zr_nxt;
            op_r       <= op_nxt;
            imm_r      <= imm_nxt;
            done_r     <= done_nxt;
            rom_rd_r   <= rom_rd_nxt;
            rom_addr_r <= rom_addr_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign op_ready   = !in_second;
    assign op_done    = done_r;
    assign rom_rd     = rom_rd_r;
    assign rom_addr   = rom_addr_r;
    assign acc        = acc_r;
    assign ext        = ext_r;
    assign mem_ptr    = {pth_r, ptl_r};
    assign carry_flag = cy_r;
    assign zero_flag  = zr_r;

endmodule

// ---- ncals_core_monitor.sv ----
// Port checker for the nibble execution core
`timescale 1ns/10ps

module ncals_core_monitor (
    // Clock and control
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    // Opcode port
    input wire logic        op_valid,
    input wire logic [7:0]  op_code,
    input wire logic [7:0]  op_imm,
    input wire logic        op_ready,
    input wire logic        op_done,
    // Pointer load and table port
    input wire logic        ptr_wr,
    input wire logic [7:0]  ptr_wdata,
    input wire logic [3:0]  pc_high,
    input wire logic        rom_rd,
    input wire logic [11:0] rom_addr,
    input wire logic [7:0]  rom_data,
    // Architectural state
    input wire logic [3:0]  acc,
    input wire logic [3:0]  ext,
    input wire logic [7:0]  mem_ptr,
    input wire logic        carry_flag,
    input wire logic        zero_flag
);
    // Opcode accepted at this edge
    logic take;
    assign take = ce && op_valid && op_ready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // --------
    // Opcode effects
    // --------
    a_rotate_left:
        assert property (take && op_code == ncals_pkg::OP_ROTL |=> acc == {$past(acc[2:0]),
            $past(carry_flag)} && carry_flag == $past(acc[3])) else $error("rotate wrong");
    a_swap_ext:
        assert property (take && op_code == ncals_pkg::OP_SWAP_EXT |=> acc == $past(ext)
            && ext == $past(acc) && $stable({carry_flag, zero_flag})) else $error("xchg wrong");
    a_bcd_adjust:
        assert property (take && op_code inside {8'he6, 8'hea} |=> $stable(carry_flag) &&
            acc == $past(acc) + ($past(op_code[2]) ? 4'h6 : 4'ha)) else $error("adjust wrong");
    a_invert_acc:
        assert property (take && op_code == ncals_pkg::OP_INVERT |=> acc == ~$past(acc) &&
            zero_flag == (acc == 4'h0)) else $error("invert wrong");
    a_load_imm:
        assert property (take && op_code[7:4] == 4'hc |=> acc == $past(op_code[3:0]) &&
            zero_flag == (acc == 4'h0)) else $error("load imm wrong");
    a_plow_cmp:
        assert property (take && op_code == ncals_pkg::OP_PLOW_CMP |=> !op_ready ##1 op_done &&
            zero_flag == (mem_ptr[3:0] == $past(op_imm[3:0], 2)) && acc == $past(acc, 2) &&
            carry_flag == $past(carry_flag, 2)) else $error("ptr compare wrong");
    a_imm_cmp:
        assert property (take && op_code == ncals_pkg::OP_IMM_CMP |=> !op_ready ##1 op_done &&
            carry_flag == ($past(op_imm[3:0], 2) <= $past(acc, 2)) &&
            zero_flag == ($past(op_imm[3:0], 2) == $past(acc, 2))) else $error("cmp wrong");
    a_rom_read:
        assert property (take && op_code == ncals_pkg::OP_ROM_READ |=> rom_rd &&
            rom_addr == {$past(pc_high), $past(ext), $past(acc)} ##1 !rom_rd && op_done &&
            {acc, ext} == $past(rom_data)) else $error("table read wrong");

    // Main scenarios reached
    c_rom_read: cover property (take && op_code == ncals_pkg::OP_ROM_READ);
    c_swap_bump: cover property (take && op_code == ncals_pkg::OP_SWAP_BUMP);
    c_mem_cmp: cover property (take && op_code == ncals_pkg::OP_MEM_CMP);
endmodule

bind ncals_core ncals_core_monitor ncals_core_monitor_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .op_valid(op_valid), .op_code(op_code),
    .op_imm(op_imm), .op_ready(op_ready), .op_done(op_done), .ptr_wr(ptr_wr),
    .ptr_wdata(ptr_wdata), .pc_high(pc_high), .rom_rd(rom_rd), .rom_addr(rom_addr),
    .rom_data(rom_data), .acc(acc), .ext(ext), .mem_ptr(mem_ptr),
    .carry_flag(carry_flag), .zero_flag(zero_flag)
);

// ---- testbench.sv ----
// Self-checking bench for the nibble execution core
`timescale 1ns/10ps

module testbench;
    // Design ports and bench counters
    logic        clk, rst_b, ce, op_valid, ptr_wr, op_ready, op_done, rom_rd;
    logic        carry_flag, zero_flag;
    logic [7:0]  op_code, op_imm, ptr_wdata, rom_data, mem_ptr;
    logic [3:0]  pc_high, acc, ext;
    logic [11:0] rom_addr;
    int          errors, compares, cycles;

    ncals_core ncals_core_inst (
        .clk(clk), .rst_b(rst_b), .ce(ce), .op_valid(op_valid), .op_code(op_code),
        .op_imm(op_imm), .op_ready(op_ready), .op_done(op_done), .ptr_wr(ptr_wr),
        .ptr_wdata(ptr_wdata), .pc_high(pc_high), .rom_rd(rom_rd), .rom_addr(rom_addr),
        .rom_data(rom_data), .acc(acc), .ext(ext), .mem_ptr(mem_ptr),
        .carry_flag(carry_flag), .zero_flag(zero_flag)
    );

    // Table ROM answers while read is high, inverted otherwise
    assign rom_data = rom_rd ? rom_addr[7:0] ^ 8'h3c : ~(rom_addr[7:0] ^ 8'h3c);

    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Offer one opcode, count cycles to its completion pulse
    task automatic issue(input logic [7:0] op, output int n);
        @(negedge clk);
        op_valid = 1'b1;
        op_code = op;
        @(posedge clk);
        @(negedge clk);
        op_valid = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        check("done", 16'(op_done), 16'h1);
    endtask

    // Entry: opcode, acc, pointer, {two-cycle, carry, zero}
    task automatic step(input logic [23:0] v);
        int n;
        issue(v[23:16], n);
        check("acc", 16'(acc), 16'(v[15:12]));
        check("ptr", 16'(mem_ptr), 16'(v[11:4]));
        check("flags", 16'({carry_flag, zero_flag}), 16'(v[1:0]));
        check("cycles", 16'(n), 16'(v[2]));
    endtask

    task automatic t_reset();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        check("rst state", {acc, ext, mem_ptr}, 16'h0000);
        check("rst flags", 16'({carry_flag, zero_flag, op_ready, op_done, rom_rd}), 16'h0004);
        rst_b = 1'b1;
    endtask

    task automatic t_acc_ops();
        logic [23:0] t [$] = '{24'hc99000, 24'hf19002, 24'h013002, 24'h0d0002, 24'h0ff000,
            24'h0e0003, 24'he66002, 24'hea0003, 24'hebf002, 24'he1f000, 24'hc00001};
        foreach (t[i]) step(t[i]);
    endtask

    task automatic t_mem_alu();
        logic [23:0] t [$] = '{24'hc555a0, 24'h0255a0, 24'hc335a0, 24'h6085a0, 24'hf185a2,
            24'h20e5a0, 24'h2035a2, 24'hf565a2, 24'he745a2, 24'he555a2, 24'hfb55a3,
            24'heaf5a2, 24'hfbf5a2, 24'hc225a2, 24'hfb25a0, 24'hcaa5a0, 24'h2ca5a7,
            24'hc225a2, 24'h2d25a7};
        @(negedge clk);
        ptr_wr = 1'b1;
        ptr_wdata = 8'h5a;
        @(negedge clk);
        ptr_wr = 1'b0;
        foreach (t[i]) step(t[i]);
    endtask

    task automatic t_mem_bits();
        logic [23:0] t [$] = '{24'h2e25a0, 24'h2165a0, 24'h2f65a2, 24'h0b65a2, 24'h21d5a2,
            24'h28d5a2, 24'h2ad5a2, 24'h2185a2};
        foreach (t[i]) step(t[i]);
    endtask

    task automatic t_swap_ops();
        logic [23:0] t [$] = '{24'hc445a2, 24'ha085a6, 24'ha346a6, 24'hc996a2, 24'h0296a2,
            24'hc116a2, 24'hfe96b6, 24'hc336b2, 24'h0236b2, 24'hc776b2, 24'hff36a6,
            24'h2116a2, 24'ha610a7, 24'h6300a7};
        foreach (t[i]) step(t[i]);
        check("ext", 16'(ext), 16'h000d);
        step(24'h0300a3);
        check("ext", 16'(ext), 16'h0000);
    endtask

    // Enable low: an offered opcode leaves acc and the done pulse alone
    task automatic t_freeze();
        @(negedge clk);
        ce = 1'b0;
        op_valid = 1'b1;
        op_code = 8'hc5;
        repeat (2) @(negedge clk);
        check("frozen", 16'({acc, op_done}), 16'h0000);
        op_valid = 1'b0;
        ce = 1'b1;
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        op_valid = 1'b0;
        op_code = 8'h00;
        op_imm = 8'h0a;
        ptr_wr = 1'b0;
        ptr_wdata = 8'h00;
        pc_high = 4'h9;
        t_reset();
        t_acc_ops();
        t_mem_alu();
        t_mem_bits();
        t_swap_ops();
        t_freeze();
        t_reset();
        final_report();
    end
endmodule
